// File: core/urp_pkg.sv
package urp_pkg;
  // Setting encodings and limits
  localparam int unsigned RATIO_W        = 7;   // Percent, 20..100
  localparam int unsigned LOAD_W         = 7;   // Hundredths of In
  localparam int unsigned DELAY_W        = 16;  // Hundredths of a second
  localparam int unsigned CUR_W          = 16;  // Current sample width
  localparam logic [6:0]  RATIO_MIN      = 7'h14;
  localparam logic [6:0]  RATIO_MAX      = 7'h64;
  localparam logic [6:0]  RATIO_DEF      = 7'h14;
  localparam logic [6:0]  LOAD_MIN       = 7'h0A;
  localparam logic [6:0]  LOAD_MAX       = 7'h64;
  localparam logic [6:0]  LOAD_DEF       = 7'h0A;
  localparam logic [15:0] DELAY_MIN      = 16'h0005;
  localparam logic [15:0] DELAY_MAX      = 16'hEA60;
  localparam logic [15:0] DELAY_DEF      = 16'h2710;
  localparam logic [6:0]  PCT_FULL       = 7'h64;
  // Resolution step of the delay setting
  localparam real         DELAY_STEP_NS  = 10000000.0;
  localparam real         CLK_PERIOD_NS  = 5.0;
  localparam int unsigned TICK_CYCLES    =
    int'(DELAY_STEP_NS / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    URP_DISABLED,
    URP_TRIP,
    URP_ALARM,
    URP_TRIP_SURGE,
    URP_LATCHED
  } urp_mode_t;
endpackage

// File: core/urp_tick.sv
`timescale 1ns/1ps
`default_nettype none
// Divider giving one 10 ms enable pulse
module urp_tick #(
  parameter int unsigned DIV = urp_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } urp_tick_st_t;
  urp_tick_st_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= DIV - 1) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick = st.tick;
endmodule // urp_tick
`default_nettype wire

// File: core/urp_core.sv
// Overview of operation
// RULE1: Continuously compare negative over positive sequence current against threshold.
// RULE2: Ratio above threshold starts the operate delay timer.
// RULE3: Operate at timer expiry; ratio at or below threshold clears timer.
// RULE4: Element disabled while largest phase current is under low-load limit.
// RULE5: Low-load limit 0.10..1.00 In in 0.01 steps, default 0.10.
// RULE6: Ratio threshold 20..100 percent in 1 percent steps, default 20.
// RULE7: Operate delay 0.05..600 s in 0.01 s steps, default 100 s.
// RULE8: Five modes: disabled, trip, alarm, surge-blockable trip, latched trip.
// RULE9: Trip modes drive trip and trip pulse; alarm mode drives alarm only.
// RULE10: Surge-blockable mode suppresses detection while inrush blocking active.
// RULE11: Latched mode holds operate after trip until external reset.
// RULE12: After reset the element is off with no trip or alarm.
// RULE13: Zero positive sequence current counts as not exceeding.
`timescale 1ns/1ps
`default_nettype none
module urp_core #(
  parameter int unsigned CW       = urp_pkg::CUR_W,
  parameter int unsigned TICK_DIV = urp_pkg::TICK_CYCLES
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic [CW-1:0]                  negative_sequence_current,
  input  wire logic [CW-1:0]                  positive_sequence_current,
  input  wire logic [CW-1:0]                  phase_a_current,
  input  wire logic [CW-1:0]                  phase_b_current,
  input  wire logic [CW-1:0]                  phase_c_current,
  input  wire logic [CW-1:0]                  rated_current,
  input  wire logic [2:0]                     mode,
  input  wire logic [urp_pkg::RATIO_W-1:0]    unbalance_ratio_threshold,
  input  wire logic [urp_pkg::LOAD_W-1:0]     low_load_block,
  input  wire logic [urp_pkg::DELAY_W-1:0]    operate_delay,
  input  wire logic                           inrush_block,
  input  wire logic                           latch_reset,
  output logic                                operate,
  output logic                                protection_trip_output,
  output logic                                protection_trip_pulse,
  output logic                                alarm_output,
  output logic                                ratio_exceeded
);
  typedef struct packed {
    logic                        exceed;
    logic [urp_pkg::DELAY_W-1:0] timer;
    logic                        operate;
    logic                        latched;
    logic                        trip;
    logic                        pulse;
    logic                        alarm;
  } urp_st_t;

  urp_st_t st, next_st;
  logic    tick;

  urp_tick #(.DIV(TICK_DIV)) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  // Settings outside their range fall back to the limit
  logic [urp_pkg::RATIO_W-1:0] thr_c;
  logic [urp_pkg::LOAD_W-1:0]  load_c;
  logic [urp_pkg::DELAY_W-1:0] dly_c;
  always_comb begin
    thr_c = unbalance_ratio_threshold; // RULE6
    if (thr_c < urp_pkg::RATIO_MIN) begin
      thr_c = urp_pkg::RATIO_MIN;
    end else if (thr_c > urp_pkg::RATIO_MAX) begin
      thr_c = urp_pkg::RATIO_MAX;
    end
    load_c = low_load_block; // RULE5
    if (load_c < urp_pkg::LOAD_MIN) begin
      load_c = urp_pkg::LOAD_MIN;
    end else if (load_c > urp_pkg::LOAD_MAX) begin
      load_c = urp_pkg::LOAD_MAX;
    end
    dly_c = operate_delay; // RULE7
    if (dly_c < urp_pkg::DELAY_MIN) begin
      dly_c = urp_pkg::DELAY_MIN;
    end else if (dly_c > urp_pkg::DELAY_MAX) begin
      dly_c = urp_pkg::DELAY_MAX;
    end
  end

  // Division avoided: I2*100 > thr*I1 is the same comparison
  // Peak phase current is scaled by 100 to meet the hundredths of In
  logic [CW+6:0] lhs;
  logic [CW+6:0] rhs;
  logic [CW+6:0] iload;
  logic [CW+6:0] ipeak;
  logic [CW-1:0] imax;
  logic          above;
  logic          loaded_c;
  always_comb begin
    lhs   = (CW+7)'(negative_sequence_current) *
            (CW+7)'(urp_pkg::PCT_FULL); // RULE1
    rhs   = (CW+7)'(positive_sequence_current) * (CW+7)'(thr_c);
    above = (positive_sequence_current != '0) && (lhs > rhs); // RULE13
    imax  = phase_a_current;
    if (phase_b_current > imax) begin
      imax = phase_b_current;
    end
    if (phase_c_current > imax) begin
      imax = phase_c_current;
    end
    iload    = (CW+7)'(rated_current) * (CW+7)'(load_c);
    ipeak    = (CW+7)'(imax) * (CW+7)'(urp_pkg::PCT_FULL);
    loaded_c = !(ipeak < iload); // RULE4
  end

  // Mode decode; codes beyond the last mode behave as disabled
  logic mode_on;
  logic trip_mode;
  logic alarm_mode;
  logic surge_mode;
  logic latch_mode;
  always_comb begin
    mode_on    = 1'b0;
    trip_mode  = 1'b0;
    alarm_mode = 1'b0;
    surge_mode = 1'b0;
    latch_mode = 1'b0;
    case (mode) // RULE8
      urp_pkg::URP_TRIP: begin
        mode_on   = 1'b1;
        trip_mode = 1'b1;
      end
      urp_pkg::URP_ALARM: begin
        mode_on    = 1'b1;
        alarm_mode = 1'b1;
      end
      urp_pkg::URP_TRIP_SURGE: begin
        mode_on    = 1'b1;
        trip_mode  = 1'b1;
        surge_mode = 1'b1;
      end
      urp_pkg::URP_LATCHED: begin
        mode_on    = 1'b1;
        trip_mode  = 1'b1;
        latch_mode = 1'b1;
      end
      default: begin
        mode_on = 1'b0;
      end
    endcase
  end

  localparam logic [urp_pkg::DELAY_W-1:0] TMR_INC = 16'h0001;

  // Timer counts 10 ms ticks and saturates at the delay setting
  logic op_now;
  always_comb begin
    next_st = st;
    next_st.exceed = mode_on && above && loaded_c &&
                     !(surge_mode && inrush_block); // RULE10
    op_now = mode_on && st.exceed && (st.timer >= dly_c); // RULE3
    if (!st.exceed) begin
      next_st.timer = '0; // RULE3
    end else if (tick && (st.timer < dly_c)) begin
      next_st.timer = st.timer + TMR_INC; // RULE2
    end
    // A reset request loses against a trip in the same cycle
    next_st.latched = latch_mode &&
                      (op_now || (st.latched && !latch_reset)); // RULE11
    next_st.operate = op_now || next_st.latched;
    next_st.trip    = next_st.operate && trip_mode; // RULE9
    next_st.pulse   = next_st.trip && !st.trip; // RULE9
    next_st.alarm   = next_st.operate && alarm_mode; // RULE9
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0; // RULE12
    end else begin
      st <= next_st;
    end
  end

  assign operate                = st.operate;
  assign protection_trip_output = st.trip;
  assign protection_trip_pulse  = st.pulse;
  assign alarm_output           = st.alarm;
  assign ratio_exceeded         = st.exceed;

  property p_zero_pos;
    @(posedge core_clk) disable iff (!rst_n)
      (positive_sequence_current == '0) |=> !ratio_exceeded;
  endproperty
  a_zero_pos: assert property (p_zero_pos) // RULE13
    else $error("ratio flagged with zero positive sequence current");

  property p_low_load;
    @(posedge core_clk) disable iff (!rst_n)
      !loaded_c |=> !ratio_exceeded;
  endproperty
  a_low_load: assert property (p_low_load) // RULE4
    else $error("ratio flagged under the low load limit");

  property p_surge_block;
    @(posedge core_clk) disable iff (!rst_n)
      (surge_mode && inrush_block) |=> !ratio_exceeded;
  endproperty
  a_surge_block: assert property (p_surge_block) // RULE10
    else $error("ratio flagged while inrush blocking is active");

  property p_timer_clear;
    @(posedge core_clk) disable iff (!rst_n)
      !ratio_exceeded |=> (st.timer == '0);
  endproperty
  a_timer_clear: assert property (p_timer_clear) // RULE3
    else $error("timer kept its count after the ratio dropped");

  property p_operate_cause;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(operate) |-> $past(ratio_exceeded);
  endproperty
  a_operate_cause: assert property (p_operate_cause) // RULE3
    else $error("operate rose without a ratio excess");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (st.latched && latch_mode && !latch_reset) |=> operate;
  endproperty
  a_latch_hold: assert property (p_latch_hold) // RULE11
    else $error("latched operate dropped without a reset");

  property p_pulse_once;
    @(posedge core_clk) disable iff (!rst_n)
      protection_trip_pulse |=> !protection_trip_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) // RULE9
    else $error("trip pulse lasted more than one cycle");

  property p_route;
    @(posedge core_clk) disable iff (!rst_n)
      alarm_output |-> (operate && !protection_trip_output);
  endproperty
  a_route: assert property (p_route) // RULE9
    else $error("alarm and trip routed together");

  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      !mode_on |=> (!operate && !alarm_output && !protection_trip_output);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // RULE12
    else $error("output active while the element is off");

  property p_cov_trip;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(protection_trip_output);
  endproperty
  c_trip: cover property (p_cov_trip);

  property p_cov_alarm;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(alarm_output);
  endproperty
  c_alarm: cover property (p_cov_alarm);

  property p_cov_latched;
    @(posedge core_clk) disable iff (!rst_n)
      operate && latch_mode && !ratio_exceeded;
  endproperty
  c_latched: cover property (p_cov_latched);

  property p_cov_surge;
    @(posedge core_clk) disable iff (!rst_n)
      surge_mode && inrush_block && above;
  endproperty
  c_surge: cover property (p_cov_surge);
endmodule // urp_core
`default_nettype wire

// File: bench/urp_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module urp_meas_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] load,
  input  wire logic [15:0] unbal,
  output logic      [15:0] pos_seq,
  output logic      [15:0] neg_seq
);
  // Widened product so a 101 percent unbalance on a large load cannot wrap before the divide by 100
  always_ff @(posedge core_clk) begin
    pos_seq <= load;
    neg_seq <= 16'((32'(load) * 32'(unbal)) / 32'h64);
  end
endmodule // urp_meas_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk, rst_n, inr, op, tr, tp, al, rx, lr;
  logic [15:0] ph, ld, ub, i1, i2;
  logic [6:0]  th;
  logic [2:0]  md;
  int          bad_count, comparisons;
  urp_meas_model u_meas (.core_clk(core_clk), .load(ld), .unbal(ub),
    .pos_seq(i1), .neg_seq(i2));
  // Short tick so the delay can expire inside the run
  urp_core #(.TICK_DIV(4)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .negative_sequence_current(i2), .positive_sequence_current(i1),
    .phase_a_current(ph), .phase_b_current(16'h0010),
    .phase_c_current(ph), .rated_current(16'h0100), .mode(md),
    .unbalance_ratio_threshold(th), .low_load_block(urp_pkg::LOAD_DEF),
    .operate_delay(urp_pkg::DELAY_MIN), .inrush_block(inr),
    .latch_reset(lr), .operate(op), .protection_trip_output(tr),
    .protection_trip_pulse(tp), .alarm_output(al), .ratio_exceeded(rx));
  task automatic chk(input logic a, input logic e);
    comparisons++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_op(input logic e);
    int n;
    n = 0;
    while (op !== e && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(op, e);
    if (op !== e) begin
      wrap_up();
    end
  endtask
  // Each step is shorter than the delay: operate must stay low
  task automatic step(input logic [15:0] p, l, u, input logic [6:0] t,
                      input logic [2:0] m, input logic i, e);
    int n;
    @(posedge core_clk);
    #1;
    ph = p;
    ld = l;
    ub = u;
    th = t;
    md = m;
    inr = i;
    n = 0;
    repeat (2) @(posedge core_clk);
    #1;
    while (rx !== e && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(rx, e);
    chk(op | tr | tp | al, 1'b0);
    if (rx !== e) begin
      wrap_up();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    {ph, ld, ub, th, md, inr} = '0;
    lr = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    chk(rx | op | tr | tp | al, 1'b0);
    step(16'h0200, 16'h0200, 16'h0015, 7'h14, 3'h1, 1'b0, 1'b1);
    step(16'h0200, 16'h0200, 16'h0014, 7'h14, 3'h1, 1'b0, 1'b0);
    step(16'h0200, 16'h0000, 16'h0000, 7'h14, 3'h1, 1'b0, 1'b0);
    step(16'h0019, 16'h0200, 16'h0032, 7'h14, 3'h1, 1'b0, 1'b0);
    step(16'h001A, 16'h0200, 16'h0032, 7'h14, 3'h1, 1'b0, 1'b1);
    step(16'h0200, 16'h0200, 16'h0032, 7'h14, 3'h3, 1'b1, 1'b0);
    step(16'h0200, 16'h0200, 16'h0032, 7'h14, 3'h1, 1'b1, 1'b1);
    step(16'h0200, 16'h0200, 16'h0064, 7'h64, 3'h2, 1'b0, 1'b0);
    step(16'h0200, 16'h0200, 16'h0065, 7'h64, 3'h4, 1'b0, 1'b1);
    wait_op(1'b1);
    chk(tr, 1'b1);
    chk(tp, 1'b1);
    chk(al, 1'b0);
    @(posedge core_clk);
    #1;
    chk(tp, 1'b0);
    ub = 16'h0000;
    repeat (3) @(posedge core_clk);
    #1;
    chk(rx, 1'b0);
    chk(op, 1'b1);
    lr = 1'b1;
    @(posedge core_clk);
    #1;
    lr = 1'b0;
    @(posedge core_clk);
    #1;
    chk(op | tr, 1'b0);
    ub = 16'h0065;
    md = 3'h2;
    wait_op(1'b1);
    chk(al, 1'b1);
    chk(tr | tp, 1'b0);
    ub = 16'h0000;
    wait_op(1'b0);
    chk(al, 1'b0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
